// [src/asd_map.svh]
// Register indices, field positions, reset values and scale constants
`ifndef ASD_MAP_SVH
`define ASD_MAP_SVH

// Register word indices; byte address is four times the index
`define ASD_IDX_ODD_FIRST 7'h67
`define ASD_IDX_ODD_SECOND 7'h68
`define ASD_IDX_EVEN_FIRST 7'h69
`define ASD_IDX_EVEN_SECOND 7'h6a
`define ASD_IDX_DIAG 7'h6b

// Argument register fields
`define ASD_ARG_MSB 11
`define ASD_ARG_RESET 12'h000
`define ASD_EN_BIT 15
`define ASD_EN_RESET 1'b0

// Diagnostic configuration fields
`define ASD_DIAG_RESET 16'h0000
`define ASD_LEVEL_MSB 15
`define ASD_LEVEL_LSB 12
`define ASD_POL_BIT 11
`define ASD_BUS_BIT 10
`define ASD_PAIR_BIT 9
`define ASD_MUXEN_BIT 8
`define ASD_SEL2_MSB 7
`define ASD_SEL2_LSB 4
`define ASD_SEL1_MSB 3
`define ASD_SEL1_LSB 0

// Scan configuration code of an on-demand calibration scan
`define ASD_SCAN_CAL 3'h3

// Test current step sizes in nA
`define ASD_CELL_LSB_NA 17'd6250
`define ASD_HV_LSB_NA 17'd3125

`endif

// [src/asd_pkg.sv]
// Types shared by the self-test and diagnostic configuration block
package asd_pkg;
	typedef logic [11:0] asd_word_t;
	typedef logic [16:0] asd_na_t;
	typedef enum logic [2:0] {
		ASD_SEL_NONE,
		ASD_SEL_ODD_FIRST,
		ASD_SEL_ODD_SECOND,
		ASD_SEL_EVEN_FIRST,
		ASD_SEL_EVEN_SECOND,
		ASD_SEL_DIAG
	} asd_reg_sel_t;
endpackage

// [src/asd_arg_sub.sv]
// Replaces converter results by stored test arguments for the ALU
`timescale 1ns/1ps
`default_nettype none
module asd_arg_sub (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Mode
	input wire logic active_i,
	input wire logic oversample_i,
	// Converter result
	input wire logic conv_valid_i,
	input wire asd_pkg::asd_word_t conv_data_i,
	input wire logic sample_odd_i,
	input wire logic conv_second_i,
	// Stored arguments
	input wire asd_pkg::asd_word_t odd_first_i,
	input wire asd_pkg::asd_word_t odd_second_i,
	input wire asd_pkg::asd_word_t even_first_i,
	input wire asd_pkg::asd_word_t even_second_i,
	// ALU feed
	output logic alu_valid_o,
	output asd_pkg::asd_word_t alu_data_o,
	output logic alu_test_data_o,
	output logic alu_cal_bypass_o
);
	import asd_pkg::*;

	logic use_odd;
	logic use_even;
	logic use_arg;
	asd_word_t odd_arg;
	asd_word_t even_arg;
	asd_word_t next_data;

	// Even samples only exist as a pair under oversampling
	assign use_odd = active_i && sample_odd_i;
	assign use_even = active_i && !sample_odd_i && oversample_i;
	assign use_arg = use_odd || use_even;
	assign odd_arg = conv_second_i ? odd_second_i : odd_first_i;
	assign even_arg = conv_second_i ? even_second_i : even_first_i;
	assign next_data = use_odd ? odd_arg : (use_even ? even_arg : conv_data_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alu_valid_o <= 1'b0;
			alu_data_o <= '0;
			alu_test_data_o <= 1'b0;
			alu_cal_bypass_o <= 1'b0;
		end else begin
			alu_valid_o <= conv_valid_i;
			alu_data_o <= next_data;
			alu_test_data_o <= use_arg;
			// Whole scan in test mode runs with unity gain and zero offset
			alu_cal_bypass_o <= active_i;
		end
	end
endmodule
`default_nettype wire

// [src/asd_current_scale.sv]
// Converts the test current level code into source currents in nA
`timescale 1ns/1ps
`default_nettype none
`include "asd_map.svh"
module asd_current_scale (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Level code
	input wire logic [3:0] level_i,
	// Currents
	output asd_pkg::asd_na_t cell_aux_na_o,
	output asd_pkg::asd_na_t hv_mux_na_o
);
	import asd_pkg::*;

	asd_na_t steps;

	// Code 0 is already one step
	assign steps = {13'h0000, level_i} + 17'd1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cell_aux_na_o <= `ASD_CELL_LSB_NA;
			hv_mux_na_o <= `ASD_HV_LSB_NA;
		end else begin
			cell_aux_na_o <= steps * `ASD_CELL_LSB_NA;
			hv_mux_na_o <= steps * `ASD_HV_LSB_NA;
		end
	end
endmodule
`default_nettype wire

// [src/asd_top.sv]
// Wishbone register file for ALU self-test arguments and diagnostic setup
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "asd_map.svh"
module asd_top #(
	parameter int ADDR_W = 10
) (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Scan context
	input wire logic [2:0] scan_cfg_i,
	input wire logic auto_balance_i,
	input wire logic oversample_i,
	// Converter results
	input wire logic conv_valid_i,
	input wire asd_pkg::asd_word_t conv_data_i,
	input wire logic sample_odd_i,
	input wire logic conv_second_i,
	// ALU feed
	output logic alu_valid_o,
	output asd_pkg::asd_word_t alu_data_o,
	output logic alu_test_data_o,
	output logic alu_cal_bypass_o,
	// Diagnostic configuration
	output logic [3:0] test_current_level_o,
	output logic test_current_polarity_o,
	output logic mux_test_output_select_o,
	output logic mux_test_pair_mode_o,
	output logic mux_test_current_enable_o,
	output logic [3:0] diag_measure_select_one_o,
	output logic [3:0] diag_measure_select_two_o,
	// Test source currents
	output asd_pkg::asd_na_t cell_aux_current_na_o,
	output asd_pkg::asd_na_t hv_mux_current_na_o
);
	import asd_pkg::*;

	localparam int IDX_W = ADDR_W - 2;

	// Byte-lane merge of a 16-bit register with the low two lanes of a write
	function automatic logic [15:0] asd_merge(
		input logic [15:0] old,
		input logic [15:0] wdat,
		input logic [1:0] sel
	);
		logic [15:0] res;
		res = old;
		if (sel[0]) begin
			res[7:0] = wdat[7:0];
		end
		if (sel[1]) begin
			res[15:8] = wdat[15:8];
		end
		return res;
	endfunction

	// Index 0 odd first, 1 odd second, 2 even first, 3 even second
	asd_word_t arg [0:3];
	logic arith_selftest_enable;
	logic [15:0] diag_config;

	logic [IDX_W-1:0] idx;
	asd_reg_sel_t reg_sel;
	logic req;
	logic wr;
	logic [15:0] cur_val;
	logic [15:0] merged;
	logic selftest_active;

	assign idx = wb_adr_i[ADDR_W-1:2];
	// One wait state: ack follows the request edge, then drops
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;

	always_comb begin
		if (idx == IDX_W'(`ASD_IDX_ODD_FIRST)) begin
			reg_sel = ASD_SEL_ODD_FIRST;
		end else if (idx == IDX_W'(`ASD_IDX_ODD_SECOND)) begin
			reg_sel = ASD_SEL_ODD_SECOND;
		end else if (idx == IDX_W'(`ASD_IDX_EVEN_FIRST)) begin
			reg_sel = ASD_SEL_EVEN_FIRST;
		end else if (idx == IDX_W'(`ASD_IDX_EVEN_SECOND)) begin
			reg_sel = ASD_SEL_EVEN_SECOND;
		end else if (idx == IDX_W'(`ASD_IDX_DIAG)) begin
			reg_sel = ASD_SEL_DIAG;
		end else begin
			reg_sel = ASD_SEL_NONE;
		end
	end

	// Readback; unused argument bits are zero
	always_comb begin
		case (reg_sel)
			ASD_SEL_ODD_FIRST: cur_val = {arith_selftest_enable, 3'h0, arg[0]};
			ASD_SEL_ODD_SECOND: cur_val = {4'h0, arg[1]};
			ASD_SEL_EVEN_FIRST: cur_val = {4'h0, arg[2]};
			ASD_SEL_EVEN_SECOND: cur_val = {4'h0, arg[3]};
			ASD_SEL_DIAG: cur_val = diag_config;
			default: cur_val = 16'h0000;
		endcase
	end

	assign merged = asd_merge(cur_val, wb_dat_i[15:0], wb_sel_i[1:0]);

	// Bus answer; unmapped words ack with zero and ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			if (req) begin
				wb_dat_o <= {16'h0000, cur_val};
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_arg
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					arg[g] <= `ASD_ARG_RESET;
				end else if (wr && reg_sel == asd_reg_sel_t'(g + 1)) begin
					// Bits 15:12 are dropped here
					arg[g] <= merged[`ASD_ARG_MSB:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arith_selftest_enable <= `ASD_EN_RESET;
		end else if (wr && reg_sel == ASD_SEL_ODD_FIRST) begin
			arith_selftest_enable <= merged[`ASD_EN_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			diag_config <= `ASD_DIAG_RESET;
		end else if (wr && reg_sel == ASD_SEL_DIAG) begin
			diag_config <= merged;
		end
	end

	// Calibration scans keep real data so coefficients are never learnt from test words
	assign selftest_active = arith_selftest_enable && (scan_cfg_i != `ASD_SCAN_CAL)
		&& !auto_balance_i;

	assign test_current_level_o = diag_config[`ASD_LEVEL_MSB:`ASD_LEVEL_LSB];
	assign test_current_polarity_o = diag_config[`ASD_POL_BIT];
	assign mux_test_output_select_o = diag_config[`ASD_BUS_BIT];
	assign mux_test_pair_mode_o = diag_config[`ASD_PAIR_BIT];
	assign mux_test_current_enable_o = diag_config[`ASD_MUXEN_BIT];
	assign diag_measure_select_two_o = diag_config[`ASD_SEL2_MSB:`ASD_SEL2_LSB];
	assign diag_measure_select_one_o = diag_config[`ASD_SEL1_MSB:`ASD_SEL1_LSB];

	asd_arg_sub u_arg_sub (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.active_i(selftest_active),
		.oversample_i(oversample_i),
		.conv_valid_i(conv_valid_i),
		.conv_data_i(conv_data_i),
		.sample_odd_i(sample_odd_i),
		.conv_second_i(conv_second_i),
		.odd_first_i(arg[0]),
		.odd_second_i(arg[1]),
		.even_first_i(arg[2]),
		.even_second_i(arg[3]),
		.alu_valid_o(alu_valid_o),
		.alu_data_o(alu_data_o),
		.alu_test_data_o(alu_test_data_o),
		.alu_cal_bypass_o(alu_cal_bypass_o)
	);

	asd_current_scale u_current_scale (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.level_i(diag_config[`ASD_LEVEL_MSB:`ASD_LEVEL_LSB]),
		.cell_aux_na_o(cell_aux_current_na_o),
		.hv_mux_na_o(hv_mux_current_na_o)
	);
endmodule
`default_nettype wire

// [test/asd_top_props.sv]
// Checker for the self-test argument and diagnostic register block
`timescale 1ns/1ps
`default_nettype none
module asd_top_props #(
	parameter int ADDR_W = 10
) (
	// System and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// Scan and converter
	input wire logic [2:0] scan_cfg_i,
	input wire logic auto_balance_i,
	input wire logic oversample_i,
	input wire logic conv_valid_i,
	input wire asd_pkg::asd_word_t conv_data_i,
	input wire logic sample_odd_i,
	input wire logic conv_second_i,
	// Outputs watched
	input wire logic alu_valid_o,
	input wire asd_pkg::asd_word_t alu_data_o,
	input wire logic alu_test_data_o,
	input wire logic alu_cal_bypass_o,
	input wire logic [3:0] test_current_level_o,
	input wire logic [3:0] diag_measure_select_one_o,
	input wire asd_pkg::asd_na_t cell_aux_current_na_o,
	input wire asd_pkg::asd_na_t hv_mux_current_na_o
);
	import asd_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Ack gates the request, so a held strobe is not taken again in its ack cycle
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire diag_wr = take && wb_we_i && wb_adr_i[ADDR_W-1:2] == 8'h6b && wb_sel_i[1:0] == 2'b11;
	chk_ack_one_cycle: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse after request");
	chk_diag_fields: assert property (diag_wr |=>
		test_current_level_o == $past(wb_dat_i[15:12])
		&& diag_measure_select_one_o == $past(wb_dat_i[3:0]))
		else $error("diagnostic fields differ from write");
	chk_odd_swap: assert property (conv_valid_i && sample_odd_i |=>
		alu_valid_o && alu_test_data_o == alu_cal_bypass_o)
		else $error("odd sample substitution wrong");
	chk_even_swap: assert property (conv_valid_i && !sample_odd_i |=>
		alu_test_data_o == (alu_cal_bypass_o && $past(oversample_i)))
		else $error("even sample substitution wrong");
	chk_scan_skip: assert property (scan_cfg_i == 3'h3 || auto_balance_i |=>
		!alu_cal_bypass_o)
		else $error("self-test active in excluded scan");
	chk_test_no_cal: assert property (alu_test_data_o |-> alu_cal_bypass_o)
		else $error("test data without calibration bypass");
	chk_pass_data: assert property (conv_valid_i ##1 !alu_test_data_o |->
		alu_data_o == $past(conv_data_i))
		else $error("converter data not passed");
	chk_no_spurious: assert property (!conv_valid_i |=> !alu_valid_o)
		else $error("alu valid without conversion");
	chk_cur_scale: assert property (1'b1 |=>
		cell_aux_current_na_o == 17'd6250 * ({13'd0, $past(test_current_level_o)} + 17'd1)
		&& hv_mux_current_na_o == 17'd3125 * ({13'd0, $past(test_current_level_o)} + 17'd1))
		else $error("test current not scaled from level");
	cover property (diag_wr);
	cover property (conv_valid_i && sample_odd_i ##1 alu_test_data_o);
	cover property (conv_valid_i && !sample_odd_i && oversample_i ##1 alu_test_data_o);
endmodule
// Bound into every instance of the top module
bind asd_top asd_top_props #(.ADDR_W(ADDR_W)) u_props (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o),
	.scan_cfg_i(scan_cfg_i),
	.auto_balance_i(auto_balance_i),
	.oversample_i(oversample_i),
	.conv_valid_i(conv_valid_i),
	.conv_data_i(conv_data_i),
	.sample_odd_i(sample_odd_i),
	.conv_second_i(conv_second_i),
	.alu_valid_o(alu_valid_o),
	.alu_data_o(alu_data_o),
	.alu_test_data_o(alu_test_data_o),
	.alu_cal_bypass_o(alu_cal_bypass_o),
	.test_current_level_o(test_current_level_o),
	.diag_measure_select_one_o(diag_measure_select_one_o),
	.cell_aux_current_na_o(cell_aux_current_na_o),
	.hv_mux_current_na_o(hv_mux_current_na_o)
);
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the self-test argument and diagnostic register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import asd_pkg::*;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [9:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
	logic [2:0] scan_cfg_i = '0;
	logic auto_balance_i = 0, oversample_i = 0, conv_valid_i = 0, sample_odd_i = 0;
	logic conv_second_i = 0, alu_valid_o, alu_test_data_o, alu_cal_bypass_o;
	asd_word_t conv_data_i = '0, alu_data_o;
	logic [3:0] test_current_level_o, diag_measure_select_one_o, diag_measure_select_two_o;
	logic test_current_polarity_o, mux_test_output_select_o;
	logic mux_test_pair_mode_o, mux_test_current_enable_o;
	asd_na_t cell_aux_current_na_o, hv_mux_current_na_o;
	asd_word_t args [4] = '{12'h123, 12'h456, 12'h789, 12'habc};
	int fail_count = 0, total_checks = 0;
	asd_top #(.ADDR_W(10)) uut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.scan_cfg_i(scan_cfg_i),
		.auto_balance_i(auto_balance_i),
		.oversample_i(oversample_i),
		.conv_valid_i(conv_valid_i),
		.conv_data_i(conv_data_i),
		.sample_odd_i(sample_odd_i),
		.conv_second_i(conv_second_i),
		.alu_valid_o(alu_valid_o),
		.alu_data_o(alu_data_o),
		.alu_test_data_o(alu_test_data_o),
		.alu_cal_bypass_o(alu_cal_bypass_o),
		.test_current_level_o(test_current_level_o),
		.test_current_polarity_o(test_current_polarity_o),
		.mux_test_output_select_o(mux_test_output_select_o),
		.mux_test_pair_mode_o(mux_test_pair_mode_o),
		.mux_test_current_enable_o(mux_test_current_enable_o),
		.diag_measure_select_one_o(diag_measure_select_one_o),
		.diag_measure_select_two_o(diag_measure_select_two_o),
		.cell_aux_current_na_o(cell_aux_current_na_o),
		.hv_mux_current_na_o(hv_mux_current_na_o)
	);
	initial forever #2.5 clk_i = ~clk_i;
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Classic cycle: hold everything until ack is sampled high
	task automatic bus(input logic we, input logic [7:0] idx, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= s;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic conv(input logic odd, input logic sec, input asd_word_t exp,
		input logic tst, input logic byp);
		@(posedge clk_i);
		conv_valid_i <= 1'b1;
		sample_odd_i <= odd;
		conv_second_i <= sec;
		conv_data_i <= 12'h5a5;
		@(posedge clk_i);
		conv_valid_i <= 1'b0;
		#1;
		check({alu_valid_o, alu_test_data_o, alu_cal_bypass_o, alu_data_o}, {1'b1, tst, byp, exp});
		// Return on an edge so the caller's next input change lands on one
		@(posedge clk_i);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 8'(8'h67 + i), 32'h0, 4'h3);
			check(rd, 40'h0);
		end
		check({cell_aux_current_na_o, hv_mux_current_na_o}, {17'd6250, 17'd3125});
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'(8'h67 + i), 32'hffffffff, 4'hf);
			bus(1'b0, 8'(8'h67 + i), 32'h0, 4'h3);
			check(rd, (i == 0) ? 40'h8fff : 40'h0fff);
			bus(1'b1, 8'(8'h67 + i), {20'h0, args[i]}, 4'h3);
		end
		bus(1'b1, 8'h6b, 32'ha5c3, 4'h3);
		bus(1'b1, 8'h6b, 32'h003c, 4'h1);
		bus(1'b0, 8'h6b, 32'h0, 4'h3);
		check(rd, 40'ha53c);
		check({test_current_level_o, test_current_polarity_o, mux_test_output_select_o,
			mux_test_pair_mode_o, mux_test_current_enable_o, diag_measure_select_two_o,
			diag_measure_select_one_o}, 40'ha53c);
		bus(1'b1, 8'h6c, 32'hffff, 4'h3);
		bus(1'b0, 8'h6c, 32'h0, 4'h3);
		check(rd, 40'h0);
		$display("test register access done");
		for (int l = 0; l < 16; l++) begin
			bus(1'b1, 8'h6b, 32'(l) << 12, 4'h3);
			@(posedge clk_i);
			#1;
			check({cell_aux_current_na_o, hv_mux_current_na_o},
				{17'(6250 * (l + 1)), 17'(3125 * (l + 1))});
		end
		$display("test current levels done");
		bus(1'b1, 8'h67, {20'h8, args[0]}, 4'h3);
		oversample_i <= 1'b1;
		for (int i = 0; i < 4; i++) conv(i < 2, 1'(i), args[i], 1'b1, 1'b1);
		oversample_i <= 1'b0;
		conv(1'b0, 1'b0, 12'h5a5, 1'b0, 1'b1);
		conv(1'b1, 1'b1, args[1], 1'b1, 1'b1);
		scan_cfg_i <= 3'h3;
		conv(1'b1, 1'b0, 12'h5a5, 1'b0, 1'b0);
		scan_cfg_i <= 3'h0;
		auto_balance_i <= 1'b1;
		conv(1'b1, 1'b1, 12'h5a5, 1'b0, 1'b0);
		auto_balance_i <= 1'b0;
		bus(1'b1, 8'h67, {20'h0, args[0]}, 4'h3);
		conv(1'b1, 1'b0, 12'h5a5, 1'b0, 1'b0);
		$display("test alu feed done");
		stop_test();
	end
	initial begin
		#20000;
		fail_count++;
		stop_test();
	end
endmodule
`default_nettype wire
